// ==== eef_params.svh ====
`ifndef EEF_PARAMS_SVH
`define EEF_PARAMS_SVH

// event flag register bit positions
`define EEF_BIT_RX_ERROR   0
`define EEF_BIT_TX_ERROR   1
`define EEF_BIT_TX_DONE    3
`define EEF_BIT_LINK       4
`define EEF_BIT_DMA_DONE   5
`define EEF_BIT_RX_PENDING 6
`define EEF_FLAGS_RST      8'h00
`define EEF_FLAGS_CLR_MASK 8'h2b
`define EEF_ENABLE_MASK    8'h7b
`define EEF_ENABLE_RST     8'h00

// status register bit positions
`define EEF_STAT_ABORT_BIT  1
`define EEF_STAT_BUFERR_BIT 6

// receive packet counter limit
`define EEF_PKT_MAX 8'hff

// phy management map
`define EEF_PHY_ENABLE_ADDR  5'h12
`define EEF_PHY_REQUEST_ADDR 5'h13
`define EEF_PHY_ENABLE_MASK  16'h0012
`define EEF_PHY_ENABLE_RST   16'h0000
`define EEF_PHY_LNK_EN_BIT   4
`define EEF_PHY_GLB_EN_BIT   1
`define EEF_PHY_LNK_FLAG_BIT 4
`define EEF_PHY_GLB_FLAG_BIT 2

`endif

// ==== eef_pkg.sv ====
package eef_pkg;
	typedef logic [7:0] eef_flags_t;
	typedef enum {EEF_SEL_NONE, EEF_SEL_ENABLE, EEF_SEL_REQUEST} eef_phy_sel_t;
endpackage

// ==== eef_core_if.sv ====
`timescale 1ns/1ns
interface eef_core_if;
	logic tx_error_evt;
	logic tx_done_evt;
	logic tx_underrun_evt;
	logic link_flag;
	logic link_irq_ok;
	modport tx (output tx_error_evt, output tx_done_evt, output tx_underrun_evt);
	modport phy (output link_flag, output link_irq_ok);
	modport core (input tx_error_evt, input tx_done_evt, input tx_underrun_evt, input link_flag, input link_irq_ok);
endinterface

// ==== eef_tx_ctrl.sv ====
`timescale 1ns/1ns
`include "eef_params.svh"
module eef_tx_ctrl (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        tx_start_i,
	input  wire logic        tx_cancel_i,
	input  wire logic        tx_complete_i,
	input  wire logic        tx_excess_coll_i,
	input  wire logic        tx_late_coll_i,
	input  wire logic        tx_forever_bit_a_limit_i,
	input  wire logic        tx_oversize_i,
	input  wire logic        tx_underrun_i,
	input  wire logic        full_duplex_i,
	input  wire logic        forever_bit_a_i,
	input  wire logic        huge_frame_allow_i,
	input  wire logic [12:0] tx_end_pointer_i,
	input  wire logic        abort_clr_i,
	eef_core_if.tx           evt,
	output logic             tx_request_o,
	output logic             tx_abort_status_o,
	output logic             status_vec_we_o,
	output logic [12:0]      status_vec_addr_o
);
	logic cause_shared;
	logic cause_local;
	logic abort;
	logic next_request;

	// collision and deferral causes cannot occur on a full-duplex link
	assign cause_shared = tx_excess_coll_i | tx_late_coll_i | (tx_forever_bit_a_limit_i & ~forever_bit_a_i);
	assign cause_local  = (tx_oversize_i & ~huge_frame_allow_i) | tx_underrun_i;
	assign abort = tx_request_o & (cause_local | (cause_shared & ~full_duplex_i));

	always_comb begin
		next_request = tx_request_o;
		if (!tx_request_o && tx_start_i) begin
			next_request = 1'h1;
		end else if (tx_request_o && (abort || tx_complete_i || tx_cancel_i)) begin
			next_request = 1'h0;
		end
	end

	assign evt.tx_done_evt     = tx_request_o & ~next_request;
	assign evt.tx_error_evt    = abort;
	assign evt.tx_underrun_evt = abort & tx_underrun_i;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_request_o <= 1'h0;
		end else begin
			tx_request_o <= next_request;
		end
	end

	// no retry: request stays low until software starts again
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_abort_status_o <= 1'h0;
		end else begin
			tx_abort_status_o <= abort | (tx_abort_status_o & ~abort_clr_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_vec_we_o   <= 1'h0;
			status_vec_addr_o <= 13'h0000;
		end else begin
			status_vec_we_o   <= abort | (tx_request_o & tx_complete_i);
			status_vec_addr_o <= 13'(tx_end_pointer_i + 13'h0001);
		end
	end
endmodule

// ==== eef_phy_events.sv ====
`timescale 1ns/1ns
`include "eef_params.svh"
module eef_phy_events (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        link_status_i,
	input  wire logic        mgmt_rd_i,
	input  wire logic        mgmt_wr_i,
	input  wire logic [4:0]  mgmt_addr_i,
	input  wire logic [15:0] mgmt_wdata_i,
	eef_core_if.phy          evt,
	output logic [15:0]      mgmt_rdata_o,
	output logic             mgmt_rvalid_o
);
	logic        link_q1;
	logic        link_q2;
	logic        link_q3;
	logic [15:0] phy_enable;
	logic        plnk_flag;
	logic        pglb_flag;
	logic        link_flag;
	logic        next_plnk;
	logic        next_pglb;
	logic        change;
	logic        req_read;
	logic        lnk_en;
	logic        glb_en;

	function automatic eef_pkg::eef_phy_sel_t decode(input logic [4:0] addr);
		if (addr == `EEF_PHY_ENABLE_ADDR) begin
			return eef_pkg::EEF_SEL_ENABLE;
		end else if (addr == `EEF_PHY_REQUEST_ADDR) begin
			return eef_pkg::EEF_SEL_REQUEST;
		end
		return eef_pkg::EEF_SEL_NONE;
	endfunction

	// pin synchroniser; edge detect looks only at later stages
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_q1 <= 1'h0;
			link_q2 <= 1'h0;
			link_q3 <= 1'h0;
		end else begin
			link_q1 <= link_status_i;
			link_q2 <= link_q1;
			link_q3 <= link_q2;
		end
	end

	assign change   = link_q2 ^ link_q3;
	assign req_read = mgmt_rd_i && (decode(mgmt_addr_i) == eef_pkg::EEF_SEL_REQUEST);
	assign lnk_en   = phy_enable[`EEF_PHY_LNK_EN_BIT];
	assign glb_en   = phy_enable[`EEF_PHY_GLB_EN_BIT];

	// a change in the read cycle survives the clear
	assign next_plnk = change | (plnk_flag & ~req_read);
	assign next_pglb = (lnk_en & (change | (plnk_flag & ~req_read))) | (pglb_flag & ~req_read);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phy_enable <= `EEF_PHY_ENABLE_RST;
		end else if (mgmt_wr_i && (decode(mgmt_addr_i) == eef_pkg::EEF_SEL_ENABLE)) begin
			phy_enable <= mgmt_wdata_i & `EEF_PHY_ENABLE_MASK;
		end
	end

	// all three flags move on the same edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			plnk_flag <= 1'h0;
			pglb_flag <= 1'h0;
			link_flag <= 1'h0;
		end else begin
			plnk_flag <= next_plnk;
			pglb_flag <= next_pglb;
			link_flag <= next_pglb & lnk_en & glb_en;
		end
	end

	assign evt.link_flag   = link_flag;
	assign evt.link_irq_ok = lnk_en & glb_en;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mgmt_rdata_o  <= 16'h0000;
			mgmt_rvalid_o <= 1'h0;
		end else begin
			mgmt_rvalid_o <= mgmt_rd_i;
			if (mgmt_rd_i) begin
				case (decode(mgmt_addr_i))
					eef_pkg::EEF_SEL_ENABLE: begin
						mgmt_rdata_o <= phy_enable;
					end
					eef_pkg::EEF_SEL_REQUEST: begin
						mgmt_rdata_o <= 16'(({15'h0000, plnk_flag} << `EEF_PHY_LNK_FLAG_BIT)
							| ({15'h0000, pglb_flag} << `EEF_PHY_GLB_FLAG_BIT));
					end
					default: begin
						mgmt_rdata_o <= 16'h0000;
					end
				endcase
			end
		end
	end
endmodule

// ==== eef_flag_logic.sv ====
`timescale 1ns/1ns
`include "eef_params.svh"
module eef_flag_logic (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        global_ethernet_enable_i,
	input  wire logic        flags_wr_i,
	input  wire logic [7:0]  flags_wdata_i,
	input  wire logic        enable_wr_i,
	input  wire logic [7:0]  enable_wdata_i,
	input  wire logic        status_wr_i,
	input  wire logic [7:0]  status_wdata_i,
	input  wire logic        rx_packet_ok_i,
	input  wire logic        rx_no_space_i,
	input  wire logic        rx_bw_fail_i,
	input  wire logic        packet_decrement_bit_i,
	input  wire logic        dma_start_i,
	input  wire logic        dma_cancel_i,
	input  wire logic        dma_complete_i,
	input  wire logic        tx_start_i,
	input  wire logic        tx_cancel_i,
	input  wire logic        tx_complete_i,
	input  wire logic        tx_excess_coll_i,
	input  wire logic        tx_late_coll_i,
	input  wire logic        tx_forever_bit_a_limit_i,
	input  wire logic        tx_oversize_i,
	input  wire logic        tx_underrun_i,
	input  wire logic        full_duplex_i,
	input  wire logic        forever_bit_a_i,
	input  wire logic        huge_frame_allow_i,
	input  wire logic [12:0] tx_end_pointer_i,
	input  wire logic        link_status_i,
	input  wire logic        mgmt_rd_i,
	input  wire logic        mgmt_wr_i,
	input  wire logic [4:0]  mgmt_addr_i,
	input  wire logic [15:0] mgmt_wdata_i,
	output logic [7:0]       flags_o,
	output logic [7:0]       enable_o,
	output logic [7:0]       packet_counter_o,
	output logic             dma_busy_bit_o,
	output logic             tx_request_bit_o,
	output logic             tx_abort_status_o,
	output logic             buffer_error_status_o,
	output logic             rx_abort_o,
	output logic             status_vec_we_o,
	output logic [12:0]      status_vec_addr_o,
	output logic [15:0]      mgmt_rdata_o,
	output logic             mgmt_rvalid_o,
	output logic             irq_o
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_q1;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'h0;
			rst_n  <= 1'h0;
		end else begin
			rst_q1 <= 1'h1;
			rst_n  <= rst_q1;
		end
	end

	// set always beats a clear in the same cycle
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	function automatic logic sw_clear(input logic wr, input logic [7:0] data, input int pos);
		return wr & ~data[pos];
	endfunction

	eef_core_if core_if ();

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	eef_tx_ctrl u_tx (
		.clk_i              (clk_i),
		.rst_n_i            (rst_n),
		.tx_start_i         (tx_start_i),
		.tx_cancel_i        (tx_cancel_i),
		.tx_complete_i      (tx_complete_i),
		.tx_excess_coll_i   (tx_excess_coll_i),
		.tx_late_coll_i     (tx_late_coll_i),
		.tx_forever_bit_a_limit_i   (tx_forever_bit_a_limit_i),
		.tx_oversize_i      (tx_oversize_i),
		.tx_underrun_i      (tx_underrun_i),
		.full_duplex_i      (full_duplex_i),
		.forever_bit_a_i    (forever_bit_a_i),
		.huge_frame_allow_i (huge_frame_allow_i),
		.tx_end_pointer_i   (tx_end_pointer_i),
		.abort_clr_i        (sw_clear(status_wr_i, status_wdata_i, `EEF_STAT_ABORT_BIT)),
		.evt                (core_if.tx),
		.tx_request_o       (tx_request_bit_o),
		.tx_abort_status_o  (tx_abort_status_o),
		.status_vec_we_o    (status_vec_we_o),
		.status_vec_addr_o  (status_vec_addr_o)
	);

	eef_phy_events u_phy (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n),
		.link_status_i (link_status_i),
		.mgmt_rd_i     (mgmt_rd_i),
		.mgmt_wr_i     (mgmt_wr_i),
		.mgmt_addr_i   (mgmt_addr_i),
		.mgmt_wdata_i  (mgmt_wdata_i),
		.evt           (core_if.phy),
		.mgmt_rdata_o  (mgmt_rdata_o),
		.mgmt_rvalid_o (mgmt_rvalid_o)
	);

	// ------------------------------------------------------------
	// receive packet counter
	// ------------------------------------------------------------
	logic       rx_full;
	logic       rx_accept;
	logic       rx_err_evt;
	logic       pkt_dec;
	logic [7:0] next_packet_counter;
	logic       rx_pending_flag;

	assign rx_full    = (packet_counter_o == `EEF_PKT_MAX);
	assign rx_err_evt = rx_no_space_i | rx_bw_fail_i | (rx_packet_ok_i & rx_full);
	assign rx_accept  = rx_packet_ok_i & ~rx_err_evt;
	assign pkt_dec    = packet_decrement_bit_i & (packet_counter_o != 8'h00);

	always_comb begin
		case ({rx_accept, pkt_dec})
			2'h2: begin
				next_packet_counter = 8'(packet_counter_o + 8'h01);
			end
			2'h1: begin
				next_packet_counter = 8'(packet_counter_o - 8'h01);
			end
			default: begin
				next_packet_counter = packet_counter_o;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			packet_counter_o <= 8'h00;
			rx_pending_flag  <= 1'h0;
			rx_abort_o       <= 1'h0;
		end else begin
			packet_counter_o <= next_packet_counter;
			rx_pending_flag  <= (next_packet_counter != 8'h00);
			rx_abort_o       <= rx_err_evt;
		end
	end

	// ------------------------------------------------------------
	// dma busy tracking
	// ------------------------------------------------------------
	logic next_dma_busy;
	logic dma_fall;

	assign next_dma_busy = dma_busy_bit_o ? ~(dma_complete_i | dma_cancel_i) : dma_start_i;
	assign dma_fall      = dma_busy_bit_o & ~next_dma_busy;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dma_busy_bit_o <= 1'h0;
		end else begin
			dma_busy_bit_o <= next_dma_busy;
		end
	end

	// ------------------------------------------------------------
	// event flags, set without regard to enables
	// ------------------------------------------------------------
	logic dma_done_flag;
	logic tx_done_flag;
	logic tx_error_flag;
	logic rx_error_flag;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dma_done_flag <= 1'h0;
			tx_done_flag  <= 1'h0;
			tx_error_flag <= 1'h0;
			rx_error_flag <= 1'h0;
		end else begin
			dma_done_flag <= sticky(dma_done_flag, dma_fall,
				sw_clear(flags_wr_i, flags_wdata_i, `EEF_BIT_DMA_DONE));
			tx_done_flag  <= sticky(tx_done_flag, core_if.tx_done_evt | core_if.tx_error_evt,
				sw_clear(flags_wr_i, flags_wdata_i, `EEF_BIT_TX_DONE));
			tx_error_flag <= sticky(tx_error_flag, core_if.tx_error_evt,
				sw_clear(flags_wr_i, flags_wdata_i, `EEF_BIT_TX_ERROR));
			rx_error_flag <= sticky(rx_error_flag, rx_err_evt,
				sw_clear(flags_wr_i, flags_wdata_i, `EEF_BIT_RX_ERROR));
		end
	end

	// ------------------------------------------------------------
	// buffer error status, shared by rx bandwidth loss and tx underrun
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			buffer_error_status_o <= 1'h0;
		end else begin
			buffer_error_status_o <= sticky(buffer_error_status_o, rx_bw_fail_i | core_if.tx_underrun_evt,
				sw_clear(status_wr_i, status_wdata_i, `EEF_STAT_BUFERR_BIT));
		end
	end

	// ------------------------------------------------------------
	// enables and master request
	// ------------------------------------------------------------
	eef_pkg::eef_flags_t flags_vec;
	eef_pkg::eef_flags_t irq_gate;

	always_comb begin
		flags_vec = `EEF_FLAGS_RST;
		flags_vec[`EEF_BIT_RX_PENDING] = rx_pending_flag;
		flags_vec[`EEF_BIT_DMA_DONE]   = dma_done_flag;
		flags_vec[`EEF_BIT_LINK]       = core_if.link_flag;
		flags_vec[`EEF_BIT_TX_DONE]    = tx_done_flag;
		flags_vec[`EEF_BIT_TX_ERROR]   = tx_error_flag;
		flags_vec[`EEF_BIT_RX_ERROR]   = rx_error_flag;
	end

	always_comb begin
		irq_gate = flags_vec & enable_o;
		// link bit needs the phy enables as well, even if the flag lingers
		irq_gate[`EEF_BIT_LINK] = irq_gate[`EEF_BIT_LINK] & core_if.link_irq_ok;
	end

	assign flags_o = flags_vec;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_o <= `EEF_ENABLE_RST;
		end else if (enable_wr_i) begin
			enable_o <= enable_wdata_i & `EEF_ENABLE_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'h0;
		end else begin
			irq_o <= global_ethernet_enable_i & (|irq_gate);
		end
	end
endmodule

// ==== eef_flag_logic_props.sv ====
`timescale 1ns/1ns
module eef_flag_logic_props (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       global_ethernet_enable_i,
	input wire logic       flags_wr_i,
	input wire logic [7:0] flags_wdata_i,
	input wire logic       rx_bw_fail_i,
	input wire logic       tx_underrun_i,
	input wire logic       link_status_i,
	input wire logic       mgmt_rd_i,
	input wire logic [4:0] mgmt_addr_i,
	input wire logic [7:0] flags_o,
	input wire logic [7:0] enable_o,
	input wire logic [7:0] packet_counter_o,
	input wire logic       dma_busy_bit_o,
	input wire logic       tx_request_bit_o,
	input wire logic       tx_abort_status_o,
	input wire logic       buffer_error_status_o,
	input wire logic       rx_abort_o,
	input wire logic       status_vec_we_o,
	input wire logic       mgmt_rvalid_o,
	input wire logic       irq_o
);
	// ----------------------------------------
	// helper and sequences
	// ----------------------------------------
	logic irq_cause;
	// one register stage, so $past needs no expression
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			irq_cause <= 1'b0;
		else
			irq_cause <= global_ethernet_enable_i && |(flags_o & enable_o);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// pin change needs several cycles to reach the flag, so demand a quiet pin
	sequence s_link_quiet; $stable(link_status_i)[*6]; endsequence
	sequence s_req_read; mgmt_rd_i && mgmt_addr_i == 5'h13; endsequence
	sequence s_live_underrun; tx_request_bit_o && tx_underrun_i; endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_pending_count: assert property (flags_o[6] == (packet_counter_o != 8'h00))
		else $error("pending flag and counter disagree");
	a_dma_done_set: assert property ($fell(dma_busy_bit_o) |-> flags_o[5])
		else $error("dma done flag missing");
	a_txdone_on_fall: assert property ($fell(tx_request_bit_o) |-> flags_o[3])
		else $error("tx done flag missing after request fell");
	a_txdone_with_err: assert property ($rose(flags_o[1]) |-> flags_o[3])
		else $error("tx error set without tx done");
	a_rxerr_sticky: assert property (flags_o[0] && !(flags_wr_i && !flags_wdata_i[0]) |=> flags_o[0])
		else $error("rx error flag dropped");
	a_txerr_sticky: assert property (flags_o[1] && !(flags_wr_i && !flags_wdata_i[1]) |=> flags_o[1])
		else $error("tx error flag dropped");
	a_underrun_abort: assert property (s_live_underrun |=> !tx_request_bit_o && tx_abort_status_o
		&& buffer_error_status_o && status_vec_we_o && flags_o[1] && flags_o[3])
		else $error("underrun abort incomplete");
	a_bw_abort: assert property (rx_bw_fail_i |=> rx_abort_o && flags_o[0] && buffer_error_status_o)
		else $error("bandwidth abort incomplete");
	a_link_read_clear: assert property (s_link_quiet ##0 s_req_read |=> !flags_o[4] && mgmt_rvalid_o)
		else $error("request read did not clear link flag");
	a_irq_gated: assert property (irq_o == irq_cause)
		else $error("master request wrong");
endmodule
bind eef_flag_logic eef_flag_logic_props u_eef_flag_logic_props (.clk_i, .rst_n_i, .global_ethernet_enable_i,
	.flags_wr_i, .flags_wdata_i, .rx_bw_fail_i, .tx_underrun_i, .link_status_i, .mgmt_rd_i, .mgmt_addr_i,
	.flags_o, .enable_o, .packet_counter_o, .dma_busy_bit_o, .tx_request_bit_o, .tx_abort_status_o,
	.buffer_error_status_o, .rx_abort_o, .status_vec_we_o, .mgmt_rvalid_o, .irq_o);

// ==== eef_flag_logic_bench.sv ====
`timescale 1ns/1ns
module eef_flag_logic_bench;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        glb = 1'b0;
	logic [2:0]  wr_s = 3'h0;
	logic [7:0]  wd = 8'h00;
	logic [14:0] ev = 15'h0000;
	logic [2:0]  cfg = 3'h0;
	logic [12:0] endp = 13'h0abc;
	logic        link = 1'b0;
	logic        mrd_s = 1'b0;
	logic        mwr_s = 1'b0;
	logic [4:0]  ma = 5'h00;
	logic [15:0] mwd = 16'h0000;
	logic [7:0]  flags, enab, cnt;
	logic        busy, req, abrt, buferr, vwe, rvalid, irq;
	logic [12:0] vaddr;
	logic [15:0] rdata;
	int          err_total = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          vwe_seen = 0;
	int          k, m;
	logic        e;

	eef_flag_logic u_eef_flag_logic (.clk_i(clk_i), .rst_n_i(rst_n_i), .global_ethernet_enable_i(glb),
		.flags_wr_i(wr_s[0]), .flags_wdata_i(wd), .enable_wr_i(wr_s[1]), .enable_wdata_i(wd),
		.status_wr_i(wr_s[2]), .status_wdata_i(wd), .rx_packet_ok_i(ev[0]), .rx_no_space_i(ev[1]),
		.rx_bw_fail_i(ev[2]), .packet_decrement_bit_i(ev[3]), .dma_start_i(ev[4]), .dma_cancel_i(ev[5]),
		.dma_complete_i(ev[6]), .tx_start_i(ev[7]), .tx_cancel_i(ev[8]), .tx_complete_i(ev[9]),
		.tx_excess_coll_i(ev[10]), .tx_late_coll_i(ev[11]), .tx_forever_bit_a_limit_i(ev[12]), .tx_oversize_i(ev[13]),
		.tx_underrun_i(ev[14]), .full_duplex_i(cfg[0]), .forever_bit_a_i(cfg[1]), .huge_frame_allow_i(cfg[2]),
		.tx_end_pointer_i(endp), .link_status_i(link), .mgmt_rd_i(mrd_s), .mgmt_wr_i(mwr_s), .mgmt_addr_i(ma),
		.mgmt_wdata_i(mwd), .flags_o(flags), .enable_o(enab), .packet_counter_o(cnt), .dma_busy_bit_o(busy),
		.tx_request_bit_o(req), .tx_abort_status_o(abrt), .buffer_error_status_o(buferr), .rx_abort_o(),
		.status_vec_we_o(vwe), .status_vec_addr_o(vaddr), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
		.irq_o(irq));

	always #5 clk_i = ~clk_i;

	// status vector strobe is a one-cycle pulse, so count it where it stands
	always @(negedge clk_i) begin
		if (vwe === 1'b1) begin
			vwe_seen++;
		end
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// idle cycle after each strobe keeps every input to one change per time step
	task automatic pulse(input int i);
		ev = 15'h0001 << i;
		tick(1);
		ev = 15'h0000;
		tick(1);
	endtask
	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		wr_s = s;
		wd = d;
		tick(1);
		wr_s = 3'h0;
		tick(1);
	endtask
	task automatic mgmt(input logic w, input logic [4:0] a, input logic [15:0] d);
		mwr_s = w;
		mrd_s = !w;
		ma = a;
		mwd = d;
		tick(1);
		mwr_s = 1'b0;
		mrd_s = 1'b0;
		if (!w)
			chk("rvalid", 16'h0001, {15'h0000, rvalid});
		tick(1);
	endtask
	task automatic do_reset();
		rst_n_i = 1'b0;
		glb = 1'b0;
		tick(4);
		rst_n_i = 1'b1;
		tick(3);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			conclude();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		do_reset();
		chk("flags", 16'h0000, {8'h00, flags});
		mgmt(1'b0, 5'h12, 16'h0000);
		chk("phy_enable", 16'h0000, rdata);
		wr(3'h2, 8'hff);
		chk("enable", 16'h007b, {8'h00, enab});
		pulse(0);
		pulse(0);
		chk("counter", 16'h0002, {8'h00, cnt});
		wr(3'h1, 8'h00);
		chk("pending", 16'h0040, {8'h00, flags});
		chk("irq", 16'h0000, {15'h0000, irq});
		glb = 1'b1;
		tick(2);
		chk("irq", 16'h0001, {15'h0000, irq});
		pulse(3);
		pulse(3);
		pulse(3);
		chk("pending", 16'h0000, {8'h00, flags});
		chk("counter", 16'h0000, {8'h00, cnt});
		chk("irq", 16'h0000, {15'h0000, irq});
		for (k = 0; k < 255; k++)
			pulse(0);
		pulse(0);
		chk("counter", 16'h00ff, {8'h00, cnt});
		chk("rx_full", 16'h0041, {8'h00, flags});
		wr(3'h1, 8'hfe);
		pulse(1);
		tick(20);
		chk("no_space", 16'h0041, {8'h00, flags});
		chk("buf_err", 16'h0000, {15'h0000, buferr});
		wr(3'h1, 8'hfe);
		pulse(2);
		chk("bw_fail", 16'h0041, {8'h00, flags});
		chk("buf_err", 16'h0001, {15'h0000, buferr});
		pulse(4);
		chk("dma_busy", 16'h0001, {15'h0000, busy});
		pulse(6);
		chk("dma_done", 16'h0061, {8'h00, flags});
		wr(3'h1, 8'hdf);
		pulse(4);
		pulse(5);
		chk("dma_cancel", 16'h0061, {8'h00, flags});
		// every transmit cause in half, full and relaxed half duplex
		do_reset();
		for (m = 0; m < 3; m++) begin
			for (k = 10; k < 15; k++) begin
				cfg = (m == 1) ? 3'h1 : (m == 2) ? 3'h6 : 3'h0;
				e = (m == 1) ? (k > 12) : (m == 2) ? (k != 12 && k != 13) : 1'b1;
				wr(3'h1, 8'h00);
				wr(3'h4, 8'h00);
				pulse(7);
				pulse(k);
				chk("tx_req", {15'h0000, !e}, {15'h0000, req});
				chk("tx_flags", e ? 16'h000a : 16'h0000, {8'h00, flags});
				chk("tx_abort", {15'h0000, e}, {15'h0000, abrt});
				chk("buf_err", {15'h0000, e && k == 14}, {15'h0000, buferr});
				if (!e) begin
					pulse(k[0] ? 9 : 8);
					chk("tx_done", 16'h0008, {8'h00, flags});
				end
			end
		end
		chk("vec_addr", 16'h0abd, {3'h0, vaddr});
		// ten aborts plus two completions write a vector; cancels write none
		chk("vec_we", 16'h000c, vwe_seen[15:0]);
		tick(10);
		chk("tx_sticky", 16'h000a, {8'h00, flags});
		do_reset();
		link = 1'b1;
		tick(6);
		chk("link_flag", 16'h0000, {8'h00, flags});
		mgmt(1'b0, 5'h13, 16'h0000);
		chk("phy_request", 16'h0010, rdata);
		mgmt(1'b0, 5'h13, 16'h0000);
		chk("phy_request", 16'h0000, rdata);
		mgmt(1'b1, 5'h12, 16'hffff);
		mgmt(1'b0, 5'h12, 16'h0000);
		chk("phy_enable", 16'h0012, rdata);
		wr(3'h2, 8'h10);
		glb = 1'b1;
		link = 1'b0;
		tick(6);
		chk("link_flag", 16'h0010, {8'h00, flags});
		chk("irq", 16'h0001, {15'h0000, irq});
		mgmt(1'b0, 5'h13, 16'h0000);
		chk("phy_request", 16'h0014, rdata);
		chk("link_flag", 16'h0000, {8'h00, flags});
		mgmt(1'b0, 5'h00, 16'h0000);
		chk("unmapped", 16'h0000, rdata);
		conclude();
	end
endmodule
